/* File: rtl/dspm_pkg.sv */
// Shared types and constants for the debug and serial pin multiplexer
package dspm_pkg;

  // Pin configuration field layout and encodings
  localparam int unsigned    CFG_W          = 4;
  localparam int unsigned    PB0_CFG_LSB    = 0;   // Port B low config [3:0]
  localparam int unsigned    PB2_CFG_LSB    = 8;   // Port B low config [11:8]
  localparam int unsigned    PC2_CFG_LSB    = 8;   // Port C low config [11:8]
  localparam logic [3:0]     CFG_ANALOG     = 4'h0;
  localparam logic [3:0]     CFG_ALT_OUT    = 4'h9;
  localparam logic [3:0]     CFG_ALT_OD     = 4'hD;
  localparam logic [3:0]     CFG_ALT_OUT_B  = 4'hB;  // Alternate push-pull, second code

  // Bit positions of single-bit controls inside wider words
  localparam int unsigned    REMAP_CH2_BIT  = 5;   // Timer 2 remap option bit
  localparam int unsigned    RELEASE_BIT    = 5;   // Debug pin release bit

  // Reset value of the pad state
  localparam logic           PAD_RST        = 1'b0;

  // Serial controller 1 function
  typedef enum logic [1:0] {
    SC_OFF,
    SC_UART,
    SC_SPI,
    SC_TWOWIRE
  } dspm_sc_mode_e;

  // Debug port mode
  typedef enum logic {
    DBG_JTAG,
    DBG_SWD
  } dspm_dbg_mode_e;

  // Drive and pull state of one pad
  typedef struct packed {
    logic analog;
    logic pull_down;
    logic pull_up;
    logic oe;
    logic out;
  } dspm_pad_s;

  // Software GPIO request for one pin
  typedef struct packed {
    logic oe;
    logic out;
  } dspm_gpio_s;

endpackage

/* File: rtl/dspm_debug_mode.sv */
// Debug port mode tracker: JTAG after reset, serial-wire on request
`timescale 1ns/1ps
`default_nettype none
module dspm_debug_mode
  import dspm_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        external_reset_low,
  input  wire logic        swd_switch_req,
  input  wire logic        jtag_switch_req,
  output dspm_dbg_mode_e   mode_q
);

  typedef struct packed {
    dspm_dbg_mode_e mode;
  } dspm_dm_state_s;

  dspm_dm_state_s st_q;
  dspm_dm_state_s st_d;

  // The switch request comes from the debug port decoder that recognises
  // the serial-wire switching sequence; this block only holds the result
  always_comb begin
    st_d = st_q;
    unique case (st_q.mode)
      DBG_JTAG: begin
        if (swd_switch_req) begin
          st_d.mode = DBG_SWD;  // [R6]
        end
      end
      DBG_SWD: begin
        if (jtag_switch_req) begin
          st_d.mode = DBG_JTAG;
        end
      end
    endcase
    // Pin reset held low forces JTAG and beats any pending switch
    if (!external_reset_low) begin
      st_d.mode = DBG_JTAG;  // [R6]
    end
  end

  // Power-up reset also lands in JTAG
  always_ff @(posedge clock) begin
    if (rst) begin
      st_q.mode <= DBG_JTAG;  // [R6]
    end else begin
      st_q <= st_d;
    end
  end

  assign mode_q = st_q.mode;

endmodule // dspm_debug_mode
`default_nettype wire

/* File: rtl/dspm_pin_mux.sv */
// Pin function multiplexer for the shared serial, timer and debug pins
// Notes on behaviour
// R1: In SPI mode, port B pin 2 feeds master or slave data input by role.
// R2: Two-wire clock drives pin only in two-wire, open-drain config, timer output not mapped.
// R3: In UART mode, port B pin 2 feeds the UART receive input.
// R4: Timer 2 channel 2 drives pin with remap set, output enabled, alternate config.
// R5: Timer 2 channel 2 capture from pin if remap set, else alternative pin.
// R6: JTAG mode after power-up or external reset; serial-wire only via switch protocol.
// R7: Debug clock pin is serial-wire clock or JTAG clock with pull-down.
// R8: Port C pin 2 is GPIO when released, else JTAG data out in JTAG.
// R9: Port C pin 2 drives async trace in serial-wire with trace and alt config.
// R10: Port C pin 3 is GPIO when released or in serial-wire mode.
// R11: Port C pin 3 is JTAG data in, pulled up, in JTAG unless released.
// R12: Port C pin 4 is GPIO, JTAG mode select, or serial-wire data, pulled up.
// R13: Port B pin 0 gives ADC reference in analog config, trace clock in alternate.
// R14: Port B pin 0 feeds interrupt A, timer 1 clock, timer 2 clock mask.
// R15: Pins with no special function stay under plain GPIO control.
`timescale 1ns/1ps
`default_nettype none
module dspm_pin_mux
  import dspm_pkg::*;
(
  input  wire logic           clock,
  input  wire logic           rst,
  // Configuration
  input  wire dspm_sc_mode_e  serctl1_function_select,
  input  wire logic           serctl1_spi_control,
  input  wire logic [7:0]     timer2_remap_option,
  input  wire logic           timer2_channel_enable,
  input  wire logic [15:0]    port_b_low_config,
  input  wire logic [15:0]    port_c_low_config,
  input  wire logic [7:0]     debug_pin_release_config,
  input  wire logic           core_trace_enable,
  input  wire logic           core_trace_async,
  // Debug mode control
  input  wire logic           external_reset_low,
  input  wire logic           swd_switch_req,
  input  wire logic           jtag_switch_req,
  // Peripheral and core side sources
  input  wire logic           serctl1_twowire_clock_out,
  input  wire logic           timer2_channel2_out,
  input  wire logic           timer2_channel2_alt_pin,
  input  wire logic           jtag_test_data_out,
  input  wire logic           jtag_test_data_out_oe,
  input  wire logic           serial_wire_trace_out,
  input  wire logic           serial_wire_data_out,
  input  wire logic           serial_wire_data_oe,
  input  wire logic           sync_trace_clock,
  input  wire dspm_gpio_s     gpio_pb2,
  input  wire dspm_gpio_s     gpio_pb0,
  input  wire dspm_gpio_s     gpio_pc2,
  input  wire dspm_gpio_s     gpio_pc3,
  input  wire dspm_gpio_s     gpio_pc4,
  // Pad inputs
  input  wire logic           port_b_pin_2_in,
  input  wire logic           port_b_pin_0_in,
  input  wire logic           port_c_pin_2_in,
  input  wire logic           port_c_pin_3_in,
  input  wire logic           port_c_pin_4_in,
  input  wire logic           debug_clock_pin_in,
  // Pad drive
  output dspm_pad_s           port_b_pin_2_pad_q,
  output dspm_pad_s           port_b_pin_0_pad_q,
  output dspm_pad_s           port_c_pin_2_pad_q,
  output dspm_pad_s           port_c_pin_3_pad_q,
  output dspm_pad_s           port_c_pin_4_pad_q,
  output logic                debug_clock_pull_down_q,
  // Peripheral and core side inputs
  output logic                serctl1_master_in_q,
  output logic                serctl1_slave_in_q,
  output logic                serctl1_twowire_clock_in_q,
  output logic                serctl1_uart_receive_q,
  output logic                timer2_channel2_in_q,
  output logic                jtag_test_clock_q,
  output logic                serial_wire_clock_q,
  output logic                jtag_test_data_in_q,
  output logic                jtag_mode_select_q,
  output logic                serial_wire_data_in_q,
  output logic                external_interrupt_a_q,
  output logic                timer1_external_clock_q,
  output logic                timer2_clock_mask_q,
  output logic [4:0]          gpio_in_q,
  output dspm_dbg_mode_e      debug_mode_q
);

  // Config field decoders; the alternate-output one is shared by several pins
  function automatic logic cfg_alt_out(input logic [CFG_W-1:0] f);
    cfg_alt_out = (f == CFG_ALT_OUT) || (f == CFG_ALT_OUT_B);
  endfunction

  function automatic logic cfg_alt_od(input logic [CFG_W-1:0] f);
    cfg_alt_od = (f == CFG_ALT_OD);
  endfunction

  function automatic logic cfg_analog(input logic [CFG_W-1:0] f);
    cfg_analog = (f == CFG_ANALOG);
  endfunction

  // Plain GPIO pad drive, no pulls
  function automatic dspm_pad_s gpio_pad(input dspm_gpio_s g);
    gpio_pad           = '0;
    gpio_pad.out       = g.out;
    gpio_pad.oe        = g.oe;
  endfunction

  // Whole state of the multiplexer
  typedef struct packed {
    dspm_pad_s  pb2;
    dspm_pad_s  pb0;
    dspm_pad_s  pc2;
    dspm_pad_s  pc3;
    dspm_pad_s  pc4;
    logic       dbg_clk_pd;
    logic       sc_master_in;
    logic       sc_slave_in;
    logic       sc_scl_in;
    logic       sc_rx;
    logic       t2c2_in;
    logic       jtag_test_clock;
    logic       swclk;
    logic       jtag_test_data_in;
    logic       jtag_mode_select;
    logic       swdio_in;
    logic       irq_a;
    logic       t1_clk;
    logic       t2_msk;
    logic [4:0] gpio_in;
  } dspm_state_s;

  dspm_state_s    st_q;
  dspm_state_s    st_d;
  dspm_dbg_mode_e dbg_mode;

  logic [CFG_W-1:0] pb2_cfg;
  logic [CFG_W-1:0] pb0_cfg;
  logic [CFG_W-1:0] pc2_cfg;
  logic             remap_ch2;
  logic             released;
  logic             swd;
  logic             jtag;

  // Debug mode lives in its own small tracker
  dspm_debug_mode u_dbg_mode (
    .clock              (clock),
    .rst                (rst),
    .external_reset_low (external_reset_low),
    .swd_switch_req     (swd_switch_req),
    .jtag_switch_req    (jtag_switch_req),
    .mode_q             (dbg_mode)
  );

  // Field extraction
  assign pb2_cfg   = port_b_low_config[PB2_CFG_LSB +: CFG_W];
  assign pb0_cfg   = port_b_low_config[PB0_CFG_LSB +: CFG_W];
  assign pc2_cfg   = port_c_low_config[PC2_CFG_LSB +: CFG_W];
  assign remap_ch2 = timer2_remap_option[REMAP_CH2_BIT];
  assign released  = debug_pin_release_config[RELEASE_BIT];
  assign swd       = (dbg_mode == DBG_SWD);
  assign jtag      = (dbg_mode == DBG_JTAG);

  // Next state: every pad and every peripheral input from current controls
  always_comb begin
    st_d = st_q;

    // Port B pin 2: shared serial controller and timer channel
    st_d.pb2 = gpio_pad(gpio_pb2);  // [R15]
    if (serctl1_function_select == SC_TWOWIRE && cfg_alt_od(pb2_cfg)
        && (!timer2_channel_enable || !remap_ch2)) begin
      // Open-drain: only ever pull low, the bus pull-up makes the high
      st_d.pb2     = '0;
      st_d.pb2.out = 1'b0;  // [R2]
      st_d.pb2.oe  = !serctl1_twowire_clock_out;  // [R2]
    end else if (remap_ch2 && timer2_channel_enable && cfg_alt_out(pb2_cfg)) begin
      st_d.pb2     = '0;
      st_d.pb2.out = timer2_channel2_out;  // [R4]
      st_d.pb2.oe  = 1'b1;  // [R4]
    end
    // SPI data inputs of serial controller are gated by mode and role so idle ones sit low; two-wire clock and UART idle high
    st_d.sc_master_in = (serctl1_function_select == SC_SPI) && serctl1_spi_control
                        && port_b_pin_2_in;  // [R1]
    st_d.sc_slave_in  = (serctl1_function_select == SC_SPI) && !serctl1_spi_control
                        && port_b_pin_2_in;  // [R1]
    st_d.sc_scl_in    = (serctl1_function_select == SC_TWOWIRE) ? port_b_pin_2_in : 1'b1;
    // UART idles high so a deselected receiver sees no start bit
    st_d.sc_rx        = (serctl1_function_select == SC_UART) ? port_b_pin_2_in : 1'b1;  // [R3]
    st_d.t2c2_in      = remap_ch2 ? port_b_pin_2_in : timer2_channel2_alt_pin;  // [R5]

    // Debug clock pin
    st_d.dbg_clk_pd = jtag;  // [R7]
    st_d.jtag_test_clock       = jtag ? debug_clock_pin_in : 1'b0;  // [R7]
    st_d.swclk      = swd ? debug_clock_pin_in : 1'b0;  // [R7]

    // Port C pin 2: trace output takes the pin only on an explicit alt config
    if (swd && core_trace_enable && core_trace_async && cfg_alt_out(pc2_cfg)) begin
      st_d.pc2         = '0;
      st_d.pc2.out     = serial_wire_trace_out;  // [R9]
      st_d.pc2.oe      = 1'b1;
      st_d.pc2.pull_up = 1'b1;  // [R9]
    end else if (released || swd) begin
      st_d.pc2 = gpio_pad(gpio_pc2);  // [R8]
    end else begin
      st_d.pc2     = '0;
      st_d.pc2.out = jtag_test_data_out;  // [R8]
      st_d.pc2.oe  = jtag_test_data_out_oe;  // [R8]
    end

    // Port C pin 3: JTAG data in unless released or in serial-wire mode
    if (released || swd) begin
      st_d.pc3  = gpio_pad(gpio_pc3);  // [R10]
      st_d.jtag_test_data_in = 1'b1;
    end else begin
      st_d.pc3         = '0;
      st_d.pc3.pull_up = 1'b1;  // [R11]
      st_d.jtag_test_data_in        = port_c_pin_3_in;  // [R11]
    end

    // Port C pin 4: mode select or serial-wire data
    st_d.jtag_mode_select     = 1'b1;
    st_d.swdio_in = 1'b1;
    if (released) begin
      st_d.pc4 = gpio_pad(gpio_pc4);  // [R12]
    end else if (swd) begin
      st_d.pc4         = '0;
      st_d.pc4.out     = serial_wire_data_out;  // [R12]
      st_d.pc4.oe      = serial_wire_data_oe;  // [R12]
      st_d.pc4.pull_up = 1'b1;  // [R12]
      st_d.swdio_in    = port_c_pin_4_in;  // [R12]
    end else begin
      st_d.pc4         = '0;
      st_d.pc4.pull_up = 1'b1;  // [R12]
      st_d.jtag_mode_select        = port_c_pin_4_in;  // [R12]
    end

    // Port B pin 0: analog reference, trace clock or GPIO
    if (cfg_analog(pb0_cfg)) begin
      st_d.pb0        = '0;
      st_d.pb0.analog = 1'b1;  // [R13]
    end else if (core_trace_enable && cfg_alt_out(pb0_cfg)) begin
      st_d.pb0     = '0;
      st_d.pb0.out = sync_trace_clock;  // [R13]
      st_d.pb0.oe  = 1'b1;  // [R13]
    end else begin
      st_d.pb0 = gpio_pad(gpio_pb0);  // [R15]
    end
    // Peripheral input paths are cut while the pad is analog; GPIO readback still sees the pin
    st_d.irq_a  = !cfg_analog(pb0_cfg) && port_b_pin_0_in;  // [R14]
    st_d.t1_clk = !cfg_analog(pb0_cfg) && port_b_pin_0_in;  // [R14]
    st_d.t2_msk = !cfg_analog(pb0_cfg) && port_b_pin_0_in;  // [R14]

    // GPIO readback of all five pins: pb2, pb0, pc2, pc3, pc4
    st_d.gpio_in = {port_c_pin_4_in, port_c_pin_3_in, port_c_pin_2_in,
                    port_b_pin_0_in, port_b_pin_2_in};  // [R15]
  end

  // State register; pads come out of reset undriven, pc3 and pc4 pulled up and the debug clock pulled down
  always_ff @(posedge clock) begin
    if (rst) begin
      st_q             <= '0;
      st_q.pc3.pull_up <= 1'b1;  // JTAG is the mode after reset
      st_q.pc4.pull_up <= 1'b1;
      st_q.dbg_clk_pd  <= 1'b1;
      st_q.sc_scl_in   <= 1'b1;
      st_q.sc_rx       <= 1'b1;
      st_q.jtag_test_data_in        <= 1'b1;
      st_q.jtag_mode_select        <= 1'b1;
      st_q.swdio_in    <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register; debug mode straight from the tracker's register
  assign port_b_pin_2_pad_q         = st_q.pb2;
  assign port_b_pin_0_pad_q         = st_q.pb0;
  assign port_c_pin_2_pad_q         = st_q.pc2;
  assign port_c_pin_3_pad_q         = st_q.pc3;
  assign port_c_pin_4_pad_q         = st_q.pc4;
  assign debug_clock_pull_down_q    = st_q.dbg_clk_pd;
  assign serctl1_master_in_q        = st_q.sc_master_in;
  assign serctl1_slave_in_q         = st_q.sc_slave_in;
  assign serctl1_twowire_clock_in_q = st_q.sc_scl_in;
  assign serctl1_uart_receive_q     = st_q.sc_rx;
  assign timer2_channel2_in_q       = st_q.t2c2_in;
  assign jtag_test_clock_q          = st_q.jtag_test_clock;
  assign serial_wire_clock_q        = st_q.swclk;
  assign jtag_test_data_in_q        = st_q.jtag_test_data_in;
  assign jtag_mode_select_q         = st_q.jtag_mode_select;
  assign serial_wire_data_in_q      = st_q.swdio_in;
  assign external_interrupt_a_q     = st_q.irq_a;
  assign timer1_external_clock_q    = st_q.t1_clk;
  assign timer2_clock_mask_q        = st_q.t2_msk;
  assign gpio_in_q                  = st_q.gpio_in;
  assign debug_mode_q               = dbg_mode;

endmodule // dspm_pin_mux
`default_nettype wire

/* File: bench/dspm_sva.sv */
// Concurrent checks on the pin multiplexer ports
`timescale 1ns/1ps
`default_nettype none
module dspm_sva
  import dspm_pkg::*;
(
  input wire logic           clock,
  input wire logic           rst,
  input wire dspm_sc_mode_e  serctl1_function_select,
  input wire logic           serctl1_spi_control,
  input wire logic [7:0]     timer2_remap_option,
  input wire logic [15:0]    port_b_low_config,
  input wire logic [7:0]     debug_pin_release_config,
  input wire logic           external_reset_low,
  input wire logic           swd_switch_req,
  input wire logic           port_b_pin_2_in,
  input wire logic           port_b_pin_0_in,
  input wire logic           port_c_pin_3_in,
  input wire logic           debug_clock_pin_in,
  input wire dspm_pad_s      port_b_pin_0_pad_q,
  input wire logic           debug_clock_pull_down_q,
  input wire logic           serctl1_master_in_q,
  input wire logic           serctl1_uart_receive_q,
  input wire logic           timer2_channel2_in_q,
  input wire logic           jtag_test_clock_q,
  input wire logic           jtag_test_data_in_q,
  input wire logic           external_interrupt_a_q,
  input wire dspm_dbg_mode_e debug_mode_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // Every routed input shows its pin one cycle later
  chk_spi_master_in: assert property (
    serctl1_function_select == SC_SPI && serctl1_spi_control |=> serctl1_master_in_q == $past(port_b_pin_2_in))
    else $error("master data input does not follow pin");
  chk_uart_rx_in: assert property (
    serctl1_function_select == SC_UART |=> serctl1_uart_receive_q == $past(port_b_pin_2_in))
    else $error("uart receive does not follow pin");
  chk_capture_remap: assert property (
    timer2_remap_option[REMAP_CH2_BIT] |=> timer2_channel2_in_q == $past(port_b_pin_2_in))
    else $error("timer capture not taken from shared pin");
  // Pin reset wins over any switch request
  chk_reset_to_jtag: assert property (
    !external_reset_low |=> debug_mode_q == DBG_JTAG)
    else $error("debug mode not jtag after pin reset");
  chk_jtag_hold: assert property (
    debug_mode_q == DBG_JTAG && !swd_switch_req |=> debug_mode_q == DBG_JTAG)
    else $error("debug mode left jtag without switch");
  chk_tck_route: assert property (
    debug_mode_q == DBG_JTAG |=> debug_clock_pull_down_q && jtag_test_clock_q == $past(debug_clock_pin_in))
    else $error("jtag clock route or pull-down wrong");
  chk_tdi_route: assert property (
    debug_mode_q == DBG_JTAG && !debug_pin_release_config[RELEASE_BIT]
      |=> jtag_test_data_in_q == $past(port_c_pin_3_in))
    else $error("jtag data input does not follow pin");
  chk_vref_analog: assert property (
    port_b_low_config[PB0_CFG_LSB +: CFG_W] == CFG_ANALOG |=> port_b_pin_0_pad_q.analog && !port_b_pin_0_pad_q.oe)
    else $error("port b pin 0 not analog");
  chk_irq_a_in: assert property (
    port_b_low_config[PB0_CFG_LSB +: CFG_W] != CFG_ANALOG |=> external_interrupt_a_q == $past(port_b_pin_0_in))
    else $error("interrupt a does not follow pin");
endmodule // dspm_sva

bind dspm_pin_mux dspm_sva chk (.*);
`default_nettype wire

/* File: bench/dspm_debugger.sv */
// Behavioural external debugger on the debug pins
`timescale 1ns/1ps
`default_nettype none
module dspm_debugger (
  input  wire logic clock,
  input  wire logic frame,
  input  wire logic to_swd,
  output logic      tck_pin,
  output logic      tdi_pin,
  output logic      switch_swd,
  output logic      switch_jtag
);
  int unsigned seq_len;

  // Clock runs only inside a frame; data changes every cycle so stale levels are never trusted
  always @(negedge clock) begin
    tck_pin <= frame & ~tck_pin;
    tdi_pin <= 1'($urandom);
    seq_len <= frame ? seq_len + 1 : 0;
    switch_swd <= frame && to_swd && seq_len == 15;
    switch_jtag <= frame && !to_swd && seq_len == 15;
  end
endmodule // dspm_debugger
`default_nettype wire

/* File: bench/tb_top.sv */
// Self-checking bench for the pin multiplexer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dspm_pkg::*;
  logic           clock = 1'b0, rst = 1'b1, frame, to_swd;
  dspm_sc_mode_e  serctl1_function_select;
  logic           serctl1_spi_control, timer2_channel_enable, core_trace_enable, core_trace_async;
  logic [7:0]     timer2_remap_option, debug_pin_release_config;
  logic [15:0]    port_b_low_config, port_c_low_config;
  logic           external_reset_low, swd_switch_req, jtag_switch_req;
  logic           serctl1_twowire_clock_out, timer2_channel2_out, timer2_channel2_alt_pin;
  logic           jtag_test_data_out, jtag_test_data_out_oe, serial_wire_trace_out;
  logic           serial_wire_data_out, serial_wire_data_oe, sync_trace_clock;
  dspm_gpio_s     gpio_pb2, gpio_pb0, gpio_pc2, gpio_pc3, gpio_pc4;
  logic           port_b_pin_2_in, port_b_pin_0_in, port_c_pin_2_in, port_c_pin_3_in;
  logic           port_c_pin_4_in, debug_clock_pin_in;
  dspm_pad_s      port_b_pin_2_pad_q, port_b_pin_0_pad_q, port_c_pin_2_pad_q;
  dspm_pad_s      port_c_pin_3_pad_q, port_c_pin_4_pad_q;
  logic           debug_clock_pull_down_q, serctl1_master_in_q, serctl1_slave_in_q;
  logic           serctl1_twowire_clock_in_q, serctl1_uart_receive_q, timer2_channel2_in_q;
  logic           jtag_test_clock_q, serial_wire_clock_q, jtag_test_data_in_q, jtag_mode_select_q;
  logic           serial_wire_data_in_q, external_interrupt_a_q, timer1_external_clock_q;
  logic           timer2_clock_mask_q;
  logic [4:0]     gpio_in_q;
  dspm_dbg_mode_e debug_mode_q;
  logic [15:0]    exp_q[$];
  logic [3:0]     codes[5] = '{CFG_ANALOG, CFG_ALT_OUT, CFG_ALT_OD, CFG_ALT_OUT_B, 4'h4};
  int             mismatches = 0, samples_checked = 0;

  dspm_pin_mux dut (.*);
  dspm_debugger dbg (.clock(clock), .frame(frame), .to_swd(to_swd), .tck_pin(debug_clock_pin_in),
    .tdi_pin(port_c_pin_3_in), .switch_swd(swd_switch_req), .switch_jtag(jtag_switch_req));

  always #25 clock = ~clock;

  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Fresh random configuration and pin levels on every input except the two resets and those the debugger drives
  task automatic shuffle();
    {serctl1_spi_control, timer2_channel_enable, serctl1_twowire_clock_out, timer2_channel2_out,
     timer2_channel2_alt_pin, jtag_test_data_out, jtag_test_data_out_oe, serial_wire_data_out,
     serial_wire_data_oe, sync_trace_clock, port_b_pin_2_in, port_b_pin_0_in, port_c_pin_2_in,
     port_c_pin_4_in, serial_wire_trace_out, core_trace_enable, core_trace_async,
     gpio_pb2, gpio_pb0, gpio_pc2, gpio_pc3, gpio_pc4} = 27'($urandom);
    serctl1_function_select = dspm_sc_mode_e'($urandom_range(3));
    timer2_remap_option = 8'($urandom);
    debug_pin_release_config = 8'($urandom);
    port_b_low_config = {4'($urandom), codes[$urandom_range(4)], 4'($urandom), codes[$urandom_range(4)]};
    port_c_low_config = 16'($urandom);
  endtask

  // Drive one random cycle and note what the outputs must show after the next edge
  task automatic step(input dspm_dbg_mode_e m);
    logic [15:0] e;
    logic        tm;
    logic        rel;
    logic        sw;
    logic [3:0]  c2;
    logic [3:0]  p2;
    @(negedge clock);
    shuffle();
    tm = timer2_remap_option[REMAP_CH2_BIT] && timer2_channel_enable;
    c2 = port_b_low_config[11:8];
    p2 = port_c_low_config[11:8];
    rel = debug_pin_release_config[RELEASE_BIT];
    sw = m == DBG_SWD;
    // Second byte: the remaining serial inputs, the debug pins and the timer 1 clock
    e[15] = serctl1_function_select == SC_SPI && !serctl1_spi_control ? port_b_pin_2_in : 1'b0;
    e[14] = serctl1_function_select == SC_TWOWIRE ? port_b_pin_2_in : 1'b1;
    e[13] = !rel && !sw ? port_c_pin_4_in : 1'b1;
    e[12] = !rel && sw ? port_c_pin_4_in : 1'b1;
    e[11] = rel ? gpio_pc4.oe : sw && serial_wire_data_oe;
    e[10] = !rel;
    e[9] = port_b_low_config[3:0] == CFG_ANALOG ? 1'b0 : port_b_pin_0_in;
    if (sw && core_trace_enable && core_trace_async && (p2 == CFG_ALT_OUT || p2 == CFG_ALT_OUT_B)) e[8] = 1'b1;
    else e[8] = (rel || sw) ? gpio_pc2.oe : jtag_test_data_out_oe;
    e[7] = serctl1_function_select == SC_UART ? port_b_pin_2_in : 1'b1;
    e[6] = serctl1_function_select == SC_SPI && serctl1_spi_control ? port_b_pin_2_in : 1'b0;
    e[5] = timer2_remap_option[REMAP_CH2_BIT] ? port_b_pin_2_in : timer2_channel2_alt_pin;
    if (serctl1_function_select == SC_TWOWIRE && c2 == CFG_ALT_OD && !tm) e[4:3] = {!serctl1_twowire_clock_out, 1'b0};
    else if (tm && (c2 == CFG_ALT_OUT || c2 == CFG_ALT_OUT_B)) e[4:3] = {1'b1, timer2_channel2_out};
    else e[4:3] = {gpio_pb2.oe, gpio_pb2.oe & gpio_pb2.out};
    e[2] = (debug_pin_release_config[RELEASE_BIT] || m == DBG_SWD) ? gpio_pc3.oe : 1'b0;
    e[1] = port_b_low_config[3:0] == CFG_ANALOG ? 1'b0 : port_b_pin_0_in;
    e[0] = port_b_low_config[3:0] == CFG_ANALOG;
    exp_q.push_back(e);
  endtask

  task automatic wait_mode(input dspm_dbg_mode_e m);
    int n;
    n = 0;
    while (debug_mode_q !== m && n < 50) begin
      @(negedge clock);
      n++;
    end
    check("debug mode", 8'(debug_mode_q), 8'(m));
    if (debug_mode_q !== m) end_of_test();
  endtask

  // Oldest note meets the outputs once the launching edge has settled
  always @(posedge clock) begin
    logic [15:0] n;
    #1;
    if (exp_q.size() > 0) begin
      n = exp_q.pop_front();
      check("mux outputs", {serctl1_uart_receive_q, serctl1_master_in_q, timer2_channel2_in_q,
        port_b_pin_2_pad_q.oe, port_b_pin_2_pad_q.oe & port_b_pin_2_pad_q.out, port_c_pin_3_pad_q.oe,
        timer2_clock_mask_q, port_b_pin_0_pad_q.analog}, n[7:0]);
      check("debug pins", {serctl1_slave_in_q, serctl1_twowire_clock_in_q, jtag_mode_select_q, serial_wire_data_in_q,
        port_c_pin_4_pad_q.oe, port_c_pin_4_pad_q.pull_up, timer1_external_clock_q, port_c_pin_2_pad_q.oe}, n[15:8]);
    end
  end

  initial begin
    void'($urandom(3));
    shuffle();
    external_reset_low = 1'b1;
    frame = 1'b0;
    to_swd = 1'b0;
    repeat (10) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    check("mode after reset", 8'(debug_mode_q), 8'(DBG_JTAG));
    check("tck pull-down", 8'(debug_clock_pull_down_q), 8'h01);
    repeat (300) step(DBG_JTAG);
    // Debugger runs the switching sequence inside a frame
    frame = 1'b1;
    to_swd = 1'b1;
    wait_mode(DBG_SWD);
    frame = 1'b0;
    @(negedge clock);
    repeat (300) step(DBG_SWD);
    // Asynchronous trace on port C pin 2
    @(negedge clock);
    {core_trace_enable, core_trace_async, serial_wire_trace_out} = 3'b111;
    port_c_low_config[11:8] = CFG_ALT_OUT;
    repeat (2) @(negedge clock);
    check("trace pad", 8'({port_c_pin_2_pad_q.oe, port_c_pin_2_pad_q.out, port_c_pin_2_pad_q.pull_up}), 8'h07);
    // Pin reset forces jtag, then the debugger switches out and back
    external_reset_low = 1'b0;
    @(negedge clock);
    check("mode on pin reset", 8'(debug_mode_q), 8'(DBG_JTAG));
    external_reset_low = 1'b1;
    frame = 1'b1;
    wait_mode(DBG_SWD);
    // Two falling edges so the debugger surely sees the gap and restarts its count
    frame = 1'b0;
    repeat (2) @(negedge clock);
    frame = 1'b1;
    to_swd = 1'b0;
    wait_mode(DBG_JTAG);
    frame = 1'b0;
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
